/* File: rtl/fsq_pkg.sv */
// Shared constants for the flash / movie mode sequencer.
// Assumes a single 250 MHz system clock and an AXI4-Lite register port.
package fsq_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 4;

    // Flash timer slope: 7.98 seconds per microfarad of timing setting
    localparam real TIMER_S_PER_UF = 7.98;
    localparam int  CYC_PER_NF     = int'(TIMER_S_PER_UF * 1.0e9 / 1000.0 / CLK_PERIOD_NS);

    // Sink start-up test window
    localparam int STARTUP_TEST_US  = 10;
    localparam int STARTUP_TEST_CYC = (STARTUP_TEST_US * 1000) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
    localparam logic [7:0] REG_TIMEOUT_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS_OFS  = 8'h08;

    // Control field positions and reset values
    localparam int          CTRL_TIMER_OFF_BIT = 0;
    localparam logic        CTRL_RESET         = 1'b0;
    localparam int          TIMEOUT_W          = 10;
    localparam logic [9:0]  TIMEOUT_RESET      = 10'h02F;   // 47 nF equivalent, 375 ms

    // Status field positions
    localparam int STAT_STATE_LSB  = 0;    // 5 bits, one-hot state
    localparam int STAT_EXPIRED    = 5;
    localparam int STAT_CH_A_OK    = 6;
    localparam int STAT_CH_B_OK    = 7;
    localparam int STAT_OT_FAULT   = 8;
    localparam int STAT_OV_FLAG    = 9;
    localparam int STAT_REQ_LSB    = 10;   // flash, movie, inhibit

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_TEST  = 5'h02,
        ST_MOVIE = 5'h04,
        ST_FLASH = 5'h08,
        ST_LOCK  = 5'h10
    } fsq_state_t;

endpackage : fsq_pkg

/* File: rtl/fsq_sequencer.sv */
// Flash / movie mode sequencer for a dual-sink LED boost driver.
// Assumes request pins already synchronous per bench, but still double-flops them.
// Functional notes
// - Flash request rising edge starts flash level and loads the safety timer.
// - Timer expiry ends flash current even while flash request stays high.
// - Flash ends on request low, or earlier on timer expiry.
// - Timer-disable control stops the timer; flash lasts while request is held.
// - Timeout equals timing setting times 7.98 s per microfarad; 47 nF gives 375 ms.
// - After timeout both requests must go low before any new event.
// - After timeout movie mode stays off until flash and movie requests both return low.
// - Inhibit during flash drops both sinks to movie level while high.
// - Inhibit falling restores flash level only if request high and timer live.
// - Inhibited flash keeps movie level on both sinks; timer keeps counting.
// - Movie request rising edge starts movie level until it returns low.
// - Safety timer does not run in movie mode.
// - Flash request takes priority over movie request.
// - Both requests low disables switching and both sinks.
// - Over-temperature trip disables operation; recovers after 15 C hysteresis.
// - Over-voltage flag stops switching; resumes by itself when it clears.
// - After start-up each sink gets test current; failing sink is disabled.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module fsq_sequencer
    import fsq_pkg::*;
#(
    parameter int CYC_PER_NF_P = fsq_pkg::CYC_PER_NF
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        ARST_N,
    // Host request pins
    input  wire logic        FLASH_REQUEST,
    input  wire logic        MOVIE_REQUEST,
    input  wire logic        FLASH_INHIBIT,
    // Analog monitor flags
    input  wire logic        OT_TRIP,
    input  wire logic        OT_RECOVERED,
    input  wire logic        OV_FLAG,
    input  wire logic        SINK_A_BELOW,
    input  wire logic        SINK_B_BELOW,
    // Power stage controls
    output logic             SWITCH_EN,
    output logic             TEST_CURRENT_EN,
    output logic             SINK_A_FLASH,
    output logic             SINK_A_MOVIE,
    output logic             SINK_B_FLASH,
    output logic             SINK_B_MOVIE,
    // AXI4-Lite write address
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    fsq_state_t                 state_q;
    fsq_state_t                 state_d;
    logic [2:0]                 sync1_q;
    logic [2:0]                 sync2_q;
    logic [2:0]                 prev_q;
    logic                       fl_req;
    logic                       mv_req;
    logic                       inh;
    logic                       fl_rise;
    logic                       mv_rise;
    logic [31:0]                timer_q;
    logic                       expired;
    logic                       expired_q;
    logic [15:0]                test_cnt_q;
    logic                       test_done;
    logic [1:0]                 ch_ok_q;
    logic                       ot_fault_q;
    logic                       timer_off_q;
    logic [TIMEOUT_W-1:0]       timeout_q;
    logic [31:0]                timeout_cyc;
    logic [7:0]                 aw_addr_q;
    logic                       aw_got_q;
    logic [31:0]                w_data_q;
    logic [3:0]                 w_strb_q;
    logic                       w_got_q;
    logic                       do_write;
    logic [31:0]                rd_word;
    logic                       rd_hit;

    // Two-stage synchroniser; only the second stage and beyond are inspected
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 3'h0;
        end else begin
            sync1_q <= {FLASH_INHIBIT, MOVIE_REQUEST, FLASH_REQUEST};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign fl_req  = sync2_q[0];
    assign mv_req  = sync2_q[1];
    assign inh     = sync2_q[2];
    assign fl_rise = sync2_q[0] & ~prev_q[0];
    assign mv_rise = sync2_q[1] & ~prev_q[1];

    // Timeout, expiry and test end; setting width keeps the product inside 32 bits
    assign timeout_cyc = 32'(timeout_q) * 32'(CYC_PER_NF_P);
    assign expired     = (timer_q == 32'h0) & ~timer_off_q;
    assign test_done   = (test_cnt_q == 16'(STARTUP_TEST_CYC - 1));

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (fl_req | mv_req) begin
                    state_d = ST_TEST;
                end
            end
            ST_TEST: begin
                if (!fl_req && !mv_req) begin
                    state_d = ST_OFF;
                end else if (test_done) begin
                    state_d = fl_req ? ST_FLASH : ST_MOVIE;
                end
            end
            ST_MOVIE: begin
                if (fl_rise) begin
                    state_d = ST_FLASH;
                end else if (!mv_req) begin
                    state_d = ST_OFF;
                end
            end
            ST_FLASH: begin
                if (!fl_req) begin
                    state_d = mv_req ? ST_MOVIE : ST_OFF;
                end else if (expired) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                // Movie stays dark until both requests have dropped
                if (!fl_req && !mv_req) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Safety timer: loaded on flash entry, counts down only in flash
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_q <= 32'h0;
        end else if (state_d == ST_FLASH && state_q != ST_FLASH) begin
            timer_q <= timeout_cyc;
        end else if (state_q == ST_FLASH && !timer_off_q && timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
        end else if (state_q == ST_OFF) begin
            timer_q <= 32'h0;
        end
    end

    // Sticky expiry, visible to software until the first request seen in off after the lockout
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            expired_q <= 1'b0;
        end else if (state_q == ST_FLASH && state_d == ST_LOCK) begin
            expired_q <= 1'b1;
        end else if (state_q == ST_OFF && (fl_req | mv_req)) begin
            expired_q <= 1'b0;
        end
    end

    // Start-up test window counter
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            test_cnt_q <= 16'h0;
        end else if (state_q == ST_TEST && !test_done) begin
            test_cnt_q <= test_cnt_q + 16'h1;
        end else if (state_q != ST_TEST) begin
            test_cnt_q <= 16'h0;
        end
    end

    // Sink health judged once per enable; a shorted or unused sink stays off
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ch_ok_q <= 2'h0;
        end else if (state_q == ST_TEST && test_done) begin
            ch_ok_q <= {SINK_B_BELOW, SINK_A_BELOW};
        end
    end

    // Thermal fault with hysteresis: trip at the hot flag, clear at the cool flag
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ot_fault_q <= 1'b0;
        end else if (OT_TRIP) begin
            ot_fault_q <= 1'b1;
        end else if (OT_RECOVERED) begin
            ot_fault_q <= 1'b0;
        end
    end

    // Power stage outputs, all registered
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            SWITCH_EN       <= 1'b0;
            TEST_CURRENT_EN <= 1'b0;
            SINK_A_FLASH    <= 1'b0;
            SINK_A_MOVIE    <= 1'b0;
            SINK_B_FLASH    <= 1'b0;
            SINK_B_MOVIE    <= 1'b0;
        end else begin
            // OV only halts switching; sinks keep their level for a clean resume
            SWITCH_EN       <= (state_q == ST_TEST || state_q == ST_MOVIE
                                || state_q == ST_FLASH) && !ot_fault_q && !OV_FLAG;
            TEST_CURRENT_EN <= (state_q == ST_TEST) && !ot_fault_q;
            SINK_A_FLASH    <= (state_q == ST_FLASH) && !inh && ch_ok_q[0] && !ot_fault_q;
            SINK_B_FLASH    <= (state_q == ST_FLASH) && !inh && ch_ok_q[1] && !ot_fault_q;
            SINK_A_MOVIE    <= (state_q == ST_MOVIE || (state_q == ST_FLASH && inh))
                               && ch_ok_q[0] && !ot_fault_q;
            SINK_B_MOVIE    <= (state_q == ST_MOVIE || (state_q == ST_FLASH && inh))
                               && ch_ok_q[1] && !ot_fault_q;
        end
    end

    // AXI write channels: address and data taken independently, in either order
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= 8'h0;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
        end else if (do_write) begin
            aw_got_q  <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            w_got_q  <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_q  <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
        end else if (do_write) begin
            w_got_q  <= 1'b0;
        end
    end

    assign do_write = aw_got_q && w_got_q && !S_AXI_BVALID;

    // Ready flags drop while a beat is held, so one write at a time
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_got_q && !(S_AXI_AWVALID && S_AXI_AWREADY) && !do_write;
            S_AXI_WREADY  <= !w_got_q && !(S_AXI_WVALID && S_AXI_WREADY) && !do_write;
        end
    end

    // Register writes; lane 0 and lane 1 carry the fields
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_off_q <= CTRL_RESET;
            timeout_q   <= TIMEOUT_RESET;
        end else if (do_write) begin
            if (aw_addr_q[7:2] == REG_CTRL_OFS[7:2] && w_strb_q[0]) begin
                timer_off_q <= w_data_q[CTRL_TIMER_OFF_BIT];
            end
            if (aw_addr_q[7:2] == REG_TIMEOUT_OFS[7:2]) begin
                if (w_strb_q[0]) begin
                    timeout_q[7:0] <= w_data_q[7:0];
                end
                if (w_strb_q[1]) begin
                    timeout_q[9:8] <= w_data_q[9:8];
                end
            end
        end
    end

    // Write response; status register and unknown offsets answer SLVERR
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (aw_addr_q[7:2] == REG_CTRL_OFS[7:2]
                             || aw_addr_q[7:2] == REG_TIMEOUT_OFS[7:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (S_AXI_ARADDR[7:2])
            REG_CTRL_OFS[7:2]: begin
                rd_word[CTRL_TIMER_OFF_BIT] = timer_off_q;
            end
            REG_TIMEOUT_OFS[7:2]: begin
                rd_word[TIMEOUT_W-1:0] = timeout_q;
            end
            REG_STATUS_OFS[7:2]: begin
                rd_word[STAT_STATE_LSB +: 5] = state_q;
                rd_word[STAT_EXPIRED]        = expired_q;
                rd_word[STAT_CH_A_OK]        = ch_ok_q[0];
                rd_word[STAT_CH_B_OK]        = ch_ok_q[1];
                rd_word[STAT_OT_FAULT]       = ot_fault_q;
                rd_word[STAT_OV_FLAG]        = OV_FLAG;
                rd_word[STAT_REQ_LSB +: 3]   = sync2_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one outstanding read, answer the cycle after acceptance
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end else if (!S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

endmodule : fsq_sequencer

/* File: test/fsq_sequencer_asserts.sv */
// Checker for the flash / movie mode sequencer, bound to its top module.
// Assumes one clock domain and the request pins held by a synchronous host.
`timescale 1ns/1ps

module fsq_sequencer_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // Host pins and monitor flags
    input wire logic FLASH_REQUEST,
    input wire logic MOVIE_REQUEST,
    input wire logic FLASH_INHIBIT,
    input wire logic OT_TRIP,
    input wire logic OV_FLAG,
    // Power stage controls
    input wire logic SWITCH_EN,
    input wire logic TEST_CURRENT_EN,
    input wire logic SINK_A_FLASH,
    input wire logic SINK_A_MOVIE,
    input wire logic SINK_B_FLASH,
    input wire logic SINK_B_MOVIE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!ARST_N);

    // Any sink drawing current at some level
    wire any_sink = SINK_A_FLASH | SINK_A_MOVIE | SINK_B_FLASH | SINK_B_MOVIE;

    // Windows of 6 to 8 cycles cover the synchroniser plus state and output registers; the unsynchronised OV window is 3 cycles
    a_idle_dark: assert property (
        (!FLASH_REQUEST && !MOVIE_REQUEST) [*8] |-> !(SWITCH_EN || TEST_CURRENT_EN || any_sink))
        else $error("outputs active with both requests low");
    a_inhibit_dims: assert property (
        FLASH_INHIBIT [*6] |-> !SINK_A_FLASH && !SINK_B_FLASH)
        else $error("flash level while inhibited");
    a_flash_needs_req: assert property (
        !FLASH_REQUEST [*6] |-> !SINK_A_FLASH && !SINK_B_FLASH)
        else $error("flash level without request");
    a_test_sinks_off: assert property (
        TEST_CURRENT_EN |-> !any_sink)
        else $error("sink level during start-up test");
    a_ov_stops: assert property (
        OV_FLAG [*3] |-> !SWITCH_EN)
        else $error("switching during over-voltage");
    a_ov_resumes: assert property (
        $fell(OV_FLAG) && any_sink && !OT_TRIP |-> ##[1:4] SWITCH_EN)
        else $error("switching not resumed after over-voltage");
    a_ot_shutdown: assert property (
        OT_TRIP [*6] |-> !(SWITCH_EN || TEST_CURRENT_EN || any_sink))
        else $error("operation during over-temperature");
    a_flash_over_movie: assert property (
        $rose(FLASH_REQUEST) && SINK_A_MOVIE && !FLASH_INHIBIT && !OT_TRIP
        |-> ##[2:8] SINK_A_FLASH)
        else $error("flash did not take over from movie");
    a_single_level: assert property (
        !(SINK_A_FLASH && SINK_A_MOVIE) && !(SINK_B_FLASH && SINK_B_MOVIE))
        else $error("sink at two levels at once");
endmodule : fsq_sequencer_chk

bind fsq_sequencer fsq_sequencer_chk chk_u (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .FLASH_REQUEST(FLASH_REQUEST),
    .MOVIE_REQUEST(MOVIE_REQUEST), .FLASH_INHIBIT(FLASH_INHIBIT), .OT_TRIP(OT_TRIP),
    .OV_FLAG(OV_FLAG), .SWITCH_EN(SWITCH_EN), .TEST_CURRENT_EN(TEST_CURRENT_EN),
    .SINK_A_FLASH(SINK_A_FLASH), .SINK_A_MOVIE(SINK_A_MOVIE),
    .SINK_B_FLASH(SINK_B_FLASH), .SINK_B_MOVIE(SINK_B_MOVIE));

/* File: test/fsq_host_model.sv */
// Host controller model driving the request and inhibit pins as levels.
// Assumes the bench calls its tasks from the clock's rising edge.
`timescale 1ns/1ps

module fsq_host_model (
    // Clock
    input  wire logic CLK_SYS,
    // Pins, pulled low when idle
    output logic      FLASH_REQUEST,
    output logic      MOVIE_REQUEST,
    output logic      FLASH_INHIBIT
);
    int lag = 0;  // Extra edges before a change, so a slow host is exercised too

    initial begin
        FLASH_REQUEST = 1'b0;
        MOVIE_REQUEST = 1'b0;
        FLASH_INHIBIT = 1'b0;
    end

    // Change all three pins together just after an edge
    task automatic drive(input logic f, input logic m, input logic i);
        repeat (1 + lag) @(posedge CLK_SYS);
        FLASH_REQUEST <= f;
        MOVIE_REQUEST <= m;
        FLASH_INHIBIT <= i;
    endtask : drive

    // Both requests low re-arms the timer after an expiry
    task automatic rearm;
        drive(1'b0, 1'b0, 1'b0);
    endtask : rearm
endmodule : fsq_host_model

/* File: test/fsq_sequencer_tb_top.sv */
// Self-checking bench for the flash / movie mode sequencer.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module fsq_sequencer_tb_top;
    import fsq_pkg::*;

    localparam int         CPN   = 4;      // Short timer scale keeps the run brief
    localparam logic [5:0] P_OFF = 6'h00;
    localparam logic [5:0] P_TST = 6'h30;
    localparam logic [5:0] P_MOV = 6'h25;
    localparam logic [5:0] P_FLS = 6'h2A;

    logic        CLK_SYS, ARST_N, FLASH_REQUEST, MOVIE_REQUEST, FLASH_INHIBIT;
    logic        OT_TRIP, OT_RECOVERED, OV_FLAG, SINK_A_BELOW, SINK_B_BELOW;
    logic        SWITCH_EN, TEST_CURRENT_EN, SINK_A_FLASH, SINK_A_MOVIE, SINK_B_FLASH, SINK_B_MOVIE;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data, r_data;
    logic        aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0]  b_resp, r_resp;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];
    int          failures, num_checks, seed, t_set, n;
    wire  [5:0]  pins = {SWITCH_EN, TEST_CURRENT_EN, SINK_A_FLASH, SINK_A_MOVIE,
                         SINK_B_FLASH, SINK_B_MOVIE};

    fsq_host_model host_u (.CLK_SYS(CLK_SYS), .FLASH_REQUEST(FLASH_REQUEST),
        .MOVIE_REQUEST(MOVIE_REQUEST), .FLASH_INHIBIT(FLASH_INHIBIT));

    fsq_sequencer #(.CYC_PER_NF_P(CPN)) dut_u (
        .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .FLASH_REQUEST(FLASH_REQUEST),
        .MOVIE_REQUEST(MOVIE_REQUEST), .FLASH_INHIBIT(FLASH_INHIBIT), .OT_TRIP(OT_TRIP),
        .OT_RECOVERED(OT_RECOVERED), .OV_FLAG(OV_FLAG), .SINK_A_BELOW(SINK_A_BELOW),
        .SINK_B_BELOW(SINK_B_BELOW), .SWITCH_EN(SWITCH_EN), .TEST_CURRENT_EN(TEST_CURRENT_EN),
        .SINK_A_FLASH(SINK_A_FLASH), .SINK_A_MOVIE(SINK_A_MOVIE), .SINK_B_FLASH(SINK_B_FLASH),
        .SINK_B_MOVIE(SINK_B_MOVIE), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
        .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready));

    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp

    // Bus waits are bounded; running out ends the run as a mismatch
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge CLK_SYS);
        wr_q.push_back(er);
        aw_addr <= a; w_data <= d; aw_valid <= 1'b1; w_valid <= 1'b1; b_ready <= 1'b1;
        for (k = 0; k < 64 && !(b_valid && !aw_valid && !w_valid); k++) begin
            @(posedge CLK_SYS);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
        end
        b_ready <= 1'b0;
        if (k == 64) begin failures++; report_and_stop(); end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge CLK_SYS);
        rd_q.push_back({er, ed});
        ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
        for (k = 0; k < 64 && !(r_valid && !ar_valid); k++) begin
            @(posedge CLK_SYS);
            if (ar_ready) ar_valid <= 1'b0;
        end
        r_ready <= 1'b0;
        if (k == 64) begin failures++; report_and_stop(); end
    endtask : axi_rd

    // Wait for an output pattern under a bound, or watch it hold
    task automatic wait_pins(input logic [5:0] e, input int lim);
        int k;
        for (k = 0; k < lim && pins !== e; k++) @(posedge CLK_SYS);
        cmp({28'h0, pins}, {28'h0, e});
        if (pins !== e) report_and_stop();
    endtask : wait_pins

    task automatic hold_pins(input logic [5:0] e, input int lim);
        logic [5:0] seen;
        seen = e;
        repeat (lim) begin
            @(posedge CLK_SYS);
            if (pins !== e) seen = pins;
        end
        cmp({28'h0, seen}, {28'h0, e});
    endtask : hold_pins

    // Bus results are compared in request order as they appear
    always @(posedge CLK_SYS) begin
        if (b_valid && b_ready) cmp({32'h0, b_resp}, {32'h0, wr_q.pop_front()});
        if (r_valid && r_ready) cmp({r_resp, r_data}, rd_q.pop_front());
    end

    initial begin
        seed = 32'h3860; failures = 0; num_checks = 0;
        ARST_N = 1'b0; OT_TRIP = 1'b0; OT_RECOVERED = 1'b0; OV_FLAG = 1'b0;
        SINK_A_BELOW = 1'b1; SINK_B_BELOW = 1'b1; aw_addr = 8'h00; ar_addr = 8'h00;
        w_data = 32'h0; aw_valid = 1'b0; w_valid = 1'b0; b_ready = 1'b0;
        ar_valid = 1'b0; r_ready = 1'b0;
        host_u.lag = $unsigned($random(seed)) % 4;
        repeat (16) @(posedge CLK_SYS);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        // Reset values and refused accesses
        axi_rd(REG_CTRL_OFS, 32'h0, RESP_OKAY);
        axi_rd(REG_TIMEOUT_OFS, {22'h0, TIMEOUT_RESET}, RESP_OKAY);
        axi_rd(8'h0C, 32'h0, RESP_SLVERR);
        axi_wr(REG_STATUS_OFS, 32'hFFFF_FFFF, RESP_SLVERR);
        axi_wr(8'h10, 32'h1, RESP_SLVERR);
        axi_rd(REG_CTRL_OFS, 32'h0, RESP_OKAY);
        // Movie from off: start-up test, then untimed movie level
        host_u.drive(1'b0, 1'b1, 1'b0);
        wait_pins(P_TST, 40);
        wait_pins(P_MOV, 2700);
        axi_rd(REG_STATUS_OFS, 32'h8C4, RESP_OKAY);
        hold_pins(P_MOV, 300);
        // Over-voltage, then over-temperature with hysteresis
        @(posedge CLK_SYS) OV_FLAG <= 1'b1;
        wait_pins(6'h05, 12);
        hold_pins(6'h05, 4);
        OV_FLAG <= 1'b0;
        wait_pins(P_MOV, 12);
        @(posedge CLK_SYS) OT_TRIP <= 1'b1;
        wait_pins(P_OFF, 12);
        hold_pins(P_OFF, 8);
        OT_TRIP <= 1'b0;
        hold_pins(P_OFF, 20);
        OT_RECOVERED <= 1'b1;
        wait_pins(P_MOV, 12);
        OT_RECOVERED <= 1'b0;
        // Flash over movie, inhibited and restored, then dropped
        host_u.drive(1'b1, 1'b1, 1'b0);
        wait_pins(P_FLS, 20);
        host_u.drive(1'b1, 1'b1, 1'b1);
        wait_pins(P_MOV, 20);
        host_u.drive(1'b1, 1'b1, 1'b0);
        wait_pins(P_FLS, 20);
        host_u.drive(1'b0, 1'b1, 1'b0);
        wait_pins(P_MOV, 20);
        // Timer runs out while inhibited; lock until both requests low
        host_u.drive(1'b1, 1'b1, 1'b0);
        wait_pins(P_FLS, 20);
        host_u.drive(1'b1, 1'b1, 1'b1);
        wait_pins(P_MOV, 20);
        wait_pins(P_OFF, 250);
        host_u.drive(1'b1, 1'b1, 1'b0);
        hold_pins(P_OFF, 40);
        axi_rd(REG_STATUS_OFS, 32'hCF0, RESP_OKAY);
        host_u.drive(1'b0, 1'b1, 1'b0);
        hold_pins(P_OFF, 40);
        host_u.rearm();
        hold_pins(P_OFF, 10);
        // Random short setting, well under one second of flash
        t_set = 8 + ($unsigned($random(seed)) % 16);
        axi_wr(REG_TIMEOUT_OFS, 32'(t_set), RESP_OKAY);
        axi_rd(REG_TIMEOUT_OFS, 32'(t_set), RESP_OKAY);
        host_u.drive(1'b1, 1'b0, 1'b0);
        wait_pins(P_FLS, 2700);
        for (n = 0; n < 200 && pins === P_FLS; n++) @(posedge CLK_SYS);
        cmp({33'h0, n >= t_set * CPN - 2 && n <= t_set * CPN + 3}, 34'h1);
        wait_pins(P_OFF, 4);
        host_u.rearm();
        // Timer disabled: flash lasts as long as the request
        axi_wr(REG_CTRL_OFS, 32'h1, RESP_OKAY);
        axi_rd(REG_CTRL_OFS, 32'h1, RESP_OKAY);
        host_u.drive(1'b1, 1'b0, 1'b0);
        wait_pins(P_FLS, 2700);
        hold_pins(P_FLS, 200);
        host_u.drive(1'b0, 1'b0, 1'b0);
        wait_pins(P_OFF, 20);
        axi_wr(REG_CTRL_OFS, 32'h0, RESP_OKAY);
        // Sink B fails its start-up test and stays dark
        SINK_B_BELOW <= 1'b0;
        host_u.drive(1'b0, 1'b1, 1'b0);
        wait_pins(P_TST, 40);
        wait_pins(6'h24, 2700);
        host_u.drive(1'b0, 1'b0, 1'b0);
        wait_pins(P_OFF, 20);
        report_and_stop();
    end
endmodule : fsq_sequencer_tb_top
